/* File: logic/srf_receiver.v */
// Summary of operation
// R1 - bit mode: receiver_active sets as first frame character arrives
// R2 - bit mode: CRC runs over every data character unless inhibited
// R3 - primary mode: active holds until closing flag, then frame_end_flag
// R4 - closing flag: check CRC for error, reinitialise it, unless inhibited
// R5 - next frame's first character sets active again, marked frame_start
// R6 - flags between frames are dropped without changing receiver state
// R7 - secondary mode: first character must match parameter low byte
// R8 - software checks second byte of 16-bit extended addresses
// R9 - char mode: parameter low byte is sync, used for receive only
// R10 - char mode: hunt two back-to-back sync characters to synchronise
// R11 - after sync, characters set receive_done, subject to sync dropping
// R12 - active on first char after sync, or first non-sync if dropping
// R13 - once active, CRC on unless bit 9 inhibit; sync dropping stops
// R14 - software clears receive_enable after message to reinitialise
// R15 - active read-only; cleared by reset, enable fall, abort
// R16 - secondary_line_state mirrors line; change sets change B flag
// R17 - modem_ready_state mirrors line; change sets change B flag
// R18 - dropping: sync chars right after the sync pair not presented
// R19 - software keeps sync dropping clear in bit mode
// R20 - bit mode: receive_done also on abort and on frame_end_flag
// R21 - static routing input moves line change events to change A
`timescale 1ns/1ps
`default_nettype none
`include "srf_map.vh"
module srf_receiver (
    // apb slave
    input  wire        pclk,
    input  wire        presetn,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output reg         pready,
    output reg         pslverr,
    // modem line side
    input  wire        rx_bit_strobe,
    input  wire        rx_bit,
    input  wire        sec_rx_line,
    input  wire        data_set_ready_line,
    input  wire        alt_change_route
);

// ----------------------------------------
// states and helpers
// ----------------------------------------
localparam [5:0] ST_B_HUNT = 6'h01;
localparam [5:0] ST_B_FLAG = 6'h02;
localparam [5:0] ST_B_ACT  = 6'h04;
localparam [5:0] ST_C_HUNT = 6'h08;
localparam [5:0] ST_C_SYNC = 6'h10;
localparam [5:0] ST_C_RUN  = 6'h20;

function [15:0] crc_byte;
    input [15:0] c;
    input [7:0]  d;
    integer i;
    reg [15:0] t;
    begin
        t = c;
        for (i = 7; i >= 0; i = i - 1)
            if (t[15] ^ d[i])
                t = {t[14:0], 1'b0} ^ `SRF_CRC_POLY;
            else
                t = {t[14:0], 1'b0};
        crc_byte = t;
    end
endfunction

function [4:0] reg_sel;
    input [11:0] a;
    begin
        reg_sel = {a[1:0] != 2'h0, a == `SRF_OFF_CHG,
                   a == `SRF_OFF_PARAM, a == `SRF_OFF_DBUF,
                   a == `SRF_OFF_CSR};
    end
endfunction

// ----------------------------------------
// registers
// ----------------------------------------
reg  [5:0]  state_reg;
reg  [7:0]  win_reg;
reg  [7:0]  dat_reg;
reg  [2:0]  cnt_reg;
reg  [2:0]  ones_reg;
reg  [15:0] crc_reg;
reg         active_reg;
reg         abort_seen_reg;
reg         done_reg;
reg  [15:0] buf_reg;
reg  [15:0] param_reg;
reg         drop_reg;
reg         en_reg;
reg         en_old_reg;
reg         chg_a_reg;
reg         chg_b_reg;
reg         sec_reg;
reg         rdy_reg;

wire [4:0] sel     = reg_sel(paddr);
wire       acc     = psel & penable & pready;
wire       wr      = acc & pwrite;
wire       rd      = acc & ~pwrite;
wire       char_md = param_reg[`SRF_PAR_CHARSEL];
wire       sec_md  = param_reg[`SRF_PAR_SECSEL];
wire       crc_inh = param_reg[`SRF_PAR_CRCINH];
wire [7:0] sync_ch = param_reg[7:0]; // R9
// sync dropping left on in bit mode stalls the receiver
wire       run     = en_reg & ~(drop_reg & ~char_md); // R19

// ----------------------------------------
// bit level decode
// ----------------------------------------
wire [7:0] new_win = {win_reg[6:0], rx_bit};
wire       flag_hit  = new_win == `SRF_FLAG_CHAR;
wire       abort_hit = rx_bit & (ones_reg == 3'h6);
wire       keep_bit  = ~(ones_reg == 3'h5);
wire [7:0] new_dat   = {dat_reg[6:0], rx_bit};
wire       byte_b    = keep_bit & (cnt_reg == 3'h7);
wire       byte_c    = cnt_reg == 3'h7;
wire [15:0] crc_good = char_md ? `SRF_CRC_GOOD_C : `SRF_CRC_GOOD_B;
wire       crc_err   = ~crc_inh & (crc_reg != crc_good);

// ----------------------------------------
// receiver engine
// ----------------------------------------
always @(posedge pclk or negedge presetn)
begin
    if (!presetn)
    begin
        state_reg      <= ST_B_HUNT;
        win_reg        <= 8'h00;
        dat_reg        <= 8'h00;
        cnt_reg        <= 3'h0;
        ones_reg       <= 3'h0;
        crc_reg        <= `SRF_CRC_INIT_B;
        active_reg     <= 1'b0;
        abort_seen_reg <= 1'b0;
        done_reg       <= 1'b0;
        buf_reg        <= 16'h0000;
        en_old_reg     <= 1'b0;
    end
    else
    begin
        en_old_reg <= en_reg;
        // reading the buffer hands the character to software
        if (rd && sel[1])
            done_reg <= 1'b0;
        if (!run)
        begin
            // enable fall or disabled: reinitialise
            active_reg <= 1'b0; // R15
            state_reg  <= char_md ? ST_C_HUNT : ST_B_HUNT;
            cnt_reg    <= 3'h0;
            ones_reg   <= 3'h0;
            crc_reg    <= char_md ? `SRF_CRC_INIT_C : `SRF_CRC_INIT_B;
        end
        else if (en_old_reg != en_reg)
            active_reg <= 1'b0; // R15
        else if (rx_bit_strobe)
        begin
            win_reg <= new_win;
            if (!char_md)
            begin
                ones_reg <= rx_bit ? (ones_reg == 3'h7 ? 3'h7
                            : ones_reg + 3'h1) : 3'h0;
                if (keep_bit)
                begin
                    dat_reg <= new_dat;
                    cnt_reg <= cnt_reg + 3'h1;
                end
                if (flag_hit)
                begin
                    // partial flag bits in the data path are discarded
                    cnt_reg   <= 3'h0;
                    state_reg <= ST_B_FLAG; // R6
                    crc_reg   <= `SRF_CRC_INIT_B; // R4
                    if (state_reg == ST_B_ACT)
                    begin
                        active_reg <= 1'b0; // R3
                        buf_reg    <= 16'h0000;
                        buf_reg[`SRF_BUF_END]    <= 1'b1; // R3
                        buf_reg[`SRF_BUF_CRCERR] <= crc_err; // R4
                        done_reg   <= 1'b1; // R20
                    end
                end
                else if (abort_hit)
                begin
                    state_reg <= ST_B_HUNT;
                    cnt_reg   <= 3'h0;
                    if (state_reg == ST_B_ACT ||
                        (state_reg == ST_B_FLAG && !abort_seen_reg))
                    begin
                        active_reg     <= 1'b0; // R15
                        abort_seen_reg <= 1'b1;
                        buf_reg        <= 16'h0000;
                        buf_reg[`SRF_BUF_ABORT] <= 1'b1;
                        done_reg       <= 1'b1; // R20
                    end
                end
                else if (byte_b && state_reg == ST_B_FLAG)
                begin
                    if (sec_md && new_dat != sync_ch)
                        state_reg <= ST_B_HUNT; // R7
                    else
                    begin
                        state_reg      <= ST_B_ACT;
                        active_reg     <= 1'b1; // R1
                        abort_seen_reg <= 1'b0;
                        buf_reg        <= {8'h01, new_dat}; // R5
                        done_reg       <= 1'b1;
                        if (!crc_inh)
                            crc_reg <= crc_byte(crc_reg, new_dat); // R2
                    end
                end
                else if (byte_b && state_reg == ST_B_ACT)
                begin
                    buf_reg  <= {8'h00, new_dat};
                    done_reg <= 1'b1;
                    if (!crc_inh)
                        crc_reg <= crc_byte(crc_reg, new_dat); // R2
                end
            end
            else
            begin
                cnt_reg <= cnt_reg + 3'h1;
                if (state_reg == ST_C_HUNT)
                begin
                    cnt_reg <= 3'h0;
                    if (new_win == sync_ch)
                        state_reg <= ST_C_SYNC; // R10
                end
                else if (state_reg == ST_C_SYNC && byte_c)
                    // second sync must follow directly
                    state_reg <= (new_win == sync_ch) ? ST_C_RUN
                                 : ST_C_HUNT; // R10
                else if (state_reg == ST_C_RUN && byte_c)
                begin
                    if (active_reg)
                    begin
                        // dropping is disabled once active
                        buf_reg  <= {crc_err, 7'h00, new_win}; // R13
                        done_reg <= 1'b1; // R11
                        if (!crc_inh)
                            crc_reg <= crc_byte(crc_reg, new_win);
                    end
                    else if (!(drop_reg && new_win == sync_ch)) // R18
                    begin
                        active_reg <= 1'b1; // R12
                        buf_reg    <= {8'h00, new_win};
                        done_reg   <= 1'b1; // R11
                        if (!crc_inh)
                            crc_reg <= crc_byte(`SRF_CRC_INIT_C,
                                                new_win); // R13
                    end
                end
                else if (state_reg != ST_C_SYNC && state_reg != ST_C_RUN)
                    state_reg <= ST_C_HUNT;
            end
        end
    end
end

// ----------------------------------------
// modem lines
// ----------------------------------------
wire line_chg = (sec_rx_line != sec_reg) |
                (data_set_ready_line != rdy_reg);

always @(posedge pclk or negedge presetn)
begin
    if (!presetn)
    begin
        sec_reg   <= 1'b0;
        rdy_reg   <= 1'b0;
        chg_a_reg <= 1'b0;
        chg_b_reg <= 1'b0;
    end
    else
    begin
        sec_reg <= sec_rx_line; // R16
        rdy_reg <= data_set_ready_line; // R17
        // a change in the clearing cycle is kept: set wins
        if (rd && sel[0])
            chg_a_reg <= 1'b0;
        if (rd && sel[3])
            chg_b_reg <= 1'b0;
        if (line_chg && alt_change_route)
            chg_a_reg <= 1'b1; // R21
        if (line_chg && !alt_change_route)
            chg_b_reg <= 1'b1; // R16 R17
    end
end

// ----------------------------------------
// apb slave
// ----------------------------------------
reg [31:0] rdata;

always @*
begin
    rdata = 32'h0000_0000;
    if (sel[0])
    begin
        rdata[`SRF_CSR_CHG_A] = chg_a_reg;
        rdata[`SRF_CSR_ACT]   = active_reg;
        rdata[`SRF_CSR_SEC]   = sec_reg;
        rdata[`SRF_CSR_RDY]   = rdy_reg;
        rdata[`SRF_CSR_DROP]  = drop_reg;
        rdata[`SRF_CSR_DONE]  = done_reg;
        rdata[`SRF_CSR_EN]    = en_reg;
    end
    else if (sel[1])
        rdata[15:0] = buf_reg;
    else if (sel[2])
        rdata[15:0] = param_reg;
    else if (sel[3])
    begin
        rdata[`SRF_CHG_A] = chg_a_reg;
        rdata[`SRF_CHG_B] = chg_b_reg;
    end
end

always @(posedge pclk or negedge presetn)
begin
    if (!presetn)
    begin
        pready    <= 1'b0;
        pslverr   <= 1'b0;
        prdata    <= 32'h0000_0000;
        param_reg <= `SRF_PAR_RESET;
        drop_reg  <= 1'b0;
        en_reg    <= 1'b0;
    end
    else
    begin
        // one wait state: answer registered from the first access-phase decode
        pready  <= psel & penable & ~pready;
        pslverr <= psel & penable & ~pready &
                   (sel[4] | ~|sel[3:0]);
        prdata  <= (psel & penable & ~pready & ~pwrite) ? rdata
                   : 32'h0000_0000;
        if (wr && sel[0])
        begin
            drop_reg <= pwdata[`SRF_CSR_DROP];
            en_reg   <= pwdata[`SRF_CSR_EN];
        end
        if (wr && sel[2])
            param_reg <= pwdata[15:0]; // R9
    end
end

endmodule
`default_nettype wire

/* File: logic/srf_map.vh */
`ifndef SRF_MAP_VH
`define SRF_MAP_VH
// register byte offsets
`define SRF_OFF_CSR      12'h000
`define SRF_OFF_DBUF     12'h004
`define SRF_OFF_PARAM    12'h008
`define SRF_OFF_CHG      12'h00C
// receiver_control_status fields
`define SRF_CSR_CHG_A    15
`define SRF_CSR_ACT      11
`define SRF_CSR_SEC      10
`define SRF_CSR_RDY      9
`define SRF_CSR_DROP     8
`define SRF_CSR_DONE     7
`define SRF_CSR_EN       4
// receive_data_buffer fields
`define SRF_BUF_START    8
`define SRF_BUF_END      9
`define SRF_BUF_ABORT    10
`define SRF_BUF_CRCERR   12
// parameter_register fields
`define SRF_PAR_CRCINH   9
`define SRF_PAR_SECSEL   12
`define SRF_PAR_CHARSEL  15
// change status fields
`define SRF_CHG_A        0
`define SRF_CHG_B        1
// line constants
`define SRF_FLAG_CHAR    8'h7E
`define SRF_CRC_POLY     16'h1021
`define SRF_CRC_INIT_B   16'hFFFF
`define SRF_CRC_GOOD_B   16'h1D0F
`define SRF_CRC_INIT_C   16'h0000
`define SRF_CRC_GOOD_C   16'h0000
`define SRF_PAR_RESET    16'h0000
`endif

/* File: testbench/srf_receiver_sva.sv */
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------
// register port and line mirror checks
// ------------------------------------
module srf_receiver_chk (
    // clock and reset
    input wire logic        pclk,
    input wire logic        presetn,
    // apb
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    // modem lines
    input wire logic        sec_rx_line,
    input wire logic        data_set_ready_line
);
    logic acc;
    assign acc = psel && penable && !pready;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    ready_pulse_a: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    one_wait_a: assert property (acc |=> pready)
        else $error("no answer one cycle after access");
    err_ready_a: assert property (pslverr |-> pready)
        else $error("pslverr without pready");
    idle_data_a: assert property (!pready |-> prdata == 32'h0)
        else $error("read data outside answer");
    upper_zero_a: assert property (pready |-> prdata[31:16] == 16'h0)
        else $error("upper read bits not zero");
    unmapped_err_a: assert property (acc && paddr > 12'h00C
        |=> pslverr && prdata == 32'h0)
        else $error("unmapped access not refused");
    mapped_ok_a: assert property (acc && paddr[1:0] == 2'b00
        && paddr <= 12'h00C |=> !pslverr)
        else $error("mapped access refused");
    sec_mirror_a: assert property (acc && !pwrite && paddr == 12'h000
        && $stable(sec_rx_line) && sec_rx_line == $past(sec_rx_line, 2)
        |=> prdata[10] == $past(sec_rx_line))
        else $error("secondary line copy wrong");
    rdy_mirror_a: assert property (acc && !pwrite && paddr == 12'h000
        && $stable(data_set_ready_line)
        && data_set_ready_line == $past(data_set_ready_line, 2)
        |=> prdata[9] == $past(data_set_ready_line))
        else $error("ready line copy wrong");
endmodule
bind srf_receiver srf_receiver_chk i_chk (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .sec_rx_line(sec_rx_line), .data_set_ready_line(data_set_ready_line));
`default_nettype wire

/* File: testbench/srf_modem_model.sv */
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------
// modem: serial data and status lines
// ------------------------------------
module srf_modem_model (
    // clock
    input  wire logic pclk,
    // serial data
    output var  logic rx_bit_strobe,
    output var  logic rx_bit,
    // status lines
    output var  logic sec_rx_line,
    output var  logic data_set_ready_line
);
    initial
    begin
        rx_bit_strobe = 1'b0;
        rx_bit = 1'b0;
        sec_rx_line = 1'b0;
        data_set_ready_line = 1'b0;
    end
    // msb first; gap of at least one cycle so a slow modem is seen too
    task automatic send_char(input logic [7:0] c, input int gap);
        for (int i = 7; i >= 0; i--)
        begin
            repeat (gap + 1) @(posedge pclk);
            rx_bit_strobe <= 1'b1;
            rx_bit <= c[i];
            @(posedge pclk);
            rx_bit_strobe <= 1'b0;
            // stale bit would hide a late sample
            rx_bit <= ~c[i];
        end
    endtask
    task automatic set_lines(input logic s, input logic r);
        sec_rx_line <= s;
        data_set_ready_line <= r;
    endtask
endmodule
`default_nettype wire

/* File: testbench/tb.sv */
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------
// apb driver, modem traffic, checks
// ------------------------------------
module tb;
    localparam logic [11:0] C = 12'h000, B = 12'h004;
    localparam logic [11:0] P = 12'h008, G = 12'h00C;
    localparam logic [31:0] M = 32'h00000990, F = 32'hFFFFFFFF;
    logic        pclk, presetn, psel, penable, pwrite, alt_change_route;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rnd;
    logic        pready, pslverr, rx_bit_strobe, rx_bit, sec_l, rdy_l;
    logic [64:0] exp_q[$];
    logic [64:0] note;
    logic [7:0]  dat;
    int          mismatches, n_checks;

    srf_receiver i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .rx_bit_strobe(rx_bit_strobe), .rx_bit(rx_bit),
        .sec_rx_line(sec_l), .data_set_ready_line(rdy_l),
        .alt_change_route(alt_change_route));
    srf_modem_model i_modem (.pclk(pclk), .rx_bit_strobe(rx_bit_strobe),
        .rx_bit(rx_bit), .sec_rx_line(sec_l), .data_set_ready_line(rdy_l));

    always #20 pclk = ~pclk;

    function automatic logic [31:0] xs(input logic [31:0] x);
        logic [31:0] y;
        y = x ^ (x << 13);
        y = y ^ (y >> 17);
        return y ^ (y << 5);
    endfunction

    task automatic test_done;
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    task automatic xfer(input logic w, input logic [11:0] a,
                        input logic [31:0] d);
        int n = 0;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (pready !== 1'b1 && n < 16);
        if (pready !== 1'b1)
        begin
            mismatches++;
            test_done();
        end
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    task automatic rd(input logic [11:0] a, input logic [31:0] e,
                      input logic [31:0] m = F, input logic er = 1'b0);
        exp_q.push_back({er, m, e});
        xfer(1'b0, a, 32'h0);
    endtask

    task automatic snd(input logic [7:0] c);
        rnd = xs(rnd);
        i_modem.send_char(c, int'(rnd[1:0]));
    endtask

    // oldest note against each read answer
    always @(posedge pclk)
    begin
        if (psel && penable && pready === 1'b1 && !pwrite)
        begin
            note = exp_q.pop_front();
            n_checks++;
            if ((prdata & note[63:32]) !== note[31:0] || pslverr !== note[64])
            begin
                $display("wrong value %0t: %h got %h", $time, paddr, prdata);
                mismatches++;
            end
        end
    end

    initial
    begin
        {pclk, presetn, psel, penable, pwrite, alt_change_route} = 6'h00;
        paddr = 12'h000;
        pwdata = 32'h0;
        rnd = 32'h3DEA;
        mismatches = 0;
        n_checks = 0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        for (int a = 0; a < 5; a++)
            rd(12'(4 * a), 32'h0, F, a == 4);
        i_modem.set_lines(1'b1, 1'b0);
        repeat (3) @(posedge pclk);
        rd(G, 32'h2, 32'h3);
        rd(G, 32'h0, 32'h3);
        rd(C, 32'h0400, 32'h8600);
        alt_change_route <= 1'b1;
        i_modem.set_lines(1'b1, 1'b1);
        repeat (3) @(posedge pclk);
        rd(C, 32'h8600, 32'h8600);
        rd(G, 32'h0, 32'h2);
        // bit mode, crc inhibited, drop kept clear
        xfer(1'b1, P, 32'h0200);
        xfer(1'b1, C, 32'h0010);
        snd(8'h7E);
        snd(8'h7E);
        rd(C, 32'h0010, M);
        rnd = xs(rnd);
        dat = rnd[7:0] & 8'h3B;
        snd(dat);
        rd(C, 32'h0890, M);
        rd(B, {23'h0, 1'b1, dat}, 32'h1FFF);
        snd(8'h5A);
        rd(B, 32'h005A, 32'h1FFF);
        snd(8'h7E);
        rd(C, 32'h0090, M);
        rd(B, 32'h0200, 32'h1700);
        snd(8'h33);
        rd(C, 32'h0890, M);
        rd(B, 32'h0133, 32'h1FFF);
        snd(8'hFF);
        rd(C, 32'h0090, M);
        rd(B, 32'h0400, 32'h0400);
        // secondary station, address 0xAB
        xfer(1'b1, P, 32'h12AB);
        snd(8'h7E);
        snd(8'h11);
        snd(8'h22);
        rd(C, 32'h0010, M);
        snd(8'h7E);
        snd(8'hAB);
        rd(C, 32'h0890, M);
        rd(B, 32'h01AB, 32'h1FFF);
        // second address byte reaches software untouched for its own check
        snd(8'hCD);
        rd(B, 32'h00CD, 32'h1FFF);
        xfer(1'b1, C, 32'h0);
        rd(C, 32'h0, M);
        // char mode, sync 0x16, active written but read only
        xfer(1'b1, P, 32'h8216);
        xfer(1'b1, C, 32'h0910);
        repeat (4) snd(8'h16);
        rd(C, 32'h0110, M);
        snd(8'h41);
        rd(C, 32'h0990, M);
        rd(B, 32'h0041, 32'h00FF);
        snd(8'h16);
        rd(C, 32'h0990, M);
        rd(B, 32'h0016, 32'h00FF);
        xfer(1'b1, C, 32'h0100);
        rd(C, 32'h0100, M);
        xfer(1'b1, C, 32'h0010);
        repeat (3) snd(8'h16);
        rd(C, 32'h0890, M);
        rd(B, 32'h0016, 32'h00FF);
        test_done();
    end
endmodule
`default_nettype wire
